// ---- src/cil_pkg.sv ----
// Package: constants, types and register map of the core interrupt latch
package cil_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CIL_OFS_LATCH = 8'h00;
	localparam logic [7:0] CIL_OFS_MASK = 8'h04;
	localparam logic [7:0] CIL_OFS_MODE = 8'h08;

	// ----------------------------------------
	// Latch bit positions
	// ----------------------------------------
	localparam int CIL_BIT_SOFT_REQUEST_3 = 31;
	localparam int CIL_BIT_SOFT_REQUEST_0 = 28;
	localparam int CIL_BIT_DEBUG_LOW_PRIO = 27;
	localparam int CIL_BIT_FLOAT_INVALID = 26;
	localparam int CIL_BIT_FLOAT_UNDERFLOW = 25;
	localparam int CIL_BIT_FLOAT_OVERFLOW = 24;
	localparam int CIL_BIT_FIXED_OVERFLOW = 23;
	localparam int CIL_BIT_TIMER_LOW = 22;
	localparam int CIL_BIT_RING_WRAP_IDX15 = 21;
	localparam int CIL_BIT_RESTRICTED_SEQ = 20;
	localparam int CIL_BIT_SYSTEM_EVENT = 15;
	localparam int CIL_BIT_RECURSIVE_FILTER = 14;
	localparam int CIL_BIT_FIR_FILTER = 13;
	localparam int CIL_BIT_BREAKPOINT = 12;
	localparam int CIL_BIT_TIMER_HIGH = 11;
	localparam int CIL_BIT_BAD_ADDRESS = 8;
	localparam int CIL_BIT_STACK_OVERFLOW = 7;
	localparam int CIL_BIT_BAD_INPUT = 6;
	localparam int CIL_BIT_RING_WRAP_IDX7 = 5;
	localparam int CIL_BIT_BAD_OPCODE = 4;
	localparam int CIL_BIT_PARITY = 3;
	localparam int CIL_BIT_RESET = 1;
	localparam int CIL_BIT_DEBUG_TOP = 0;

	// ----------------------------------------
	// Bit groups and reset values
	// ----------------------------------------
	localparam logic CIL_HAS_ACCEL = 1'b1;
	localparam logic [31:0] CIL_ACCEL_BITS = 32'h0000_6000;
	localparam logic [31:0] CIL_WRITABLE_BITS = 32'hfff0_f9f8;
	localparam logic [31:0] CIL_NMI_BITS = 32'h0000_0003;
	localparam logic [31:0] CIL_LATCH_RST = 32'h0000_0002;
	localparam logic [31:0] CIL_MASK_RST = 32'h0000_0000;
	localparam logic [4:0] CIL_MODE_RST = 5'h00;

	// Mode register fields
	localparam int CIL_MODE_SELF_NEST = 0;
	localparam int CIL_MODE_INSTR_PAR = 1;
	localparam int CIL_MODE_DATA_PAR = 2;
	localparam int CIL_MODE_SYS_PAR = 3;
	localparam int CIL_MODE_GLOBAL_EN = 4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		CIL_SP_NORMAL = 2'h0,
		CIL_SP_LONG = 2'h1,
		CIL_SP_SHORT = 2'h2,
		CIL_SP_BYTE = 2'h3
	} cil_space_type;

	typedef enum logic [1:0] {
		CIL_ST_IDLE = 2'b01,
		CIL_ST_WAIT = 2'b10
	} cil_state_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} cil_bus_type;

	typedef struct packed {
		logic debug_top;
		logic debug_break;
		logic debug_low;
		logic [1:0] flt_inv;
		logic [1:0] flt_unf;
		logic [1:0] flt_ovf;
		logic [1:0] fix_ovf;
		logic ring_wrap15;
		logic ring_wrap7;
		logic loop_tail_dly_branch;
		logic nest_e2_in_arith;
		logic nest_last_gap1;
		logic nest_l2_branch;
		logic sys_event;
		logic iir_done;
		logic fir_done;
		logic breakpoint;
		logic acc_valid;
		logic acc_narrow;
		cil_space_type acc_space;
		logic mod_valid;
		logic mod_sw;
		logic mod_nw;
		cil_space_type mod_space;
		logic [2:0] stack_full;
		logic io_reg_flag;
		logic unaligned_flag;
		logic bad_opcode;
		logic [2:0] par_err;
		logic [2:0] par_valid;
		logic [2:0] par_abort;
		logic soft_reset;
	} cil_evt_type;

endpackage

// ---- src/cil_sync2.sv ----
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module cil_sync2 (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	logic meta_ff;
	logic q_ff;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			meta_ff <= 1'b0;
			q_ff <= 1'b0;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule // cil_sync2

// ---- src/cil_prio_pick.sv ----
// Fixed-priority picker: lowest set bit index wins
`timescale 1ns/100ps
module cil_prio_pick (
	input wire logic [31:0] pend,
	output logic any,
	output logic [4:0] idx
);
	always_comb begin
		any = 1'b0;
		idx = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (pend[i]) begin
				any = 1'b1;
				idx = 5'(i);
			end
		end
	end
endmodule // cil_prio_pick

// ---- src/cil_latch_top.sv ----
// Core interrupt latch with register port, masking and priority request
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps
module cil_latch_top
	import cil_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic hardware_reset_pin,
	input wire cil_bus_type bus,
	output logic [31:0] rdata,
	input wire cil_evt_type evt,
	input wire logic [31:0] timer_count_value,
	input wire logic sys_event_in_service,
	input wire logic vec_ack,
	output logic irq_req,
	output logic [4:0] irq_idx,
	output logic [31:0] interrupt_latch
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic is_byte_space(input cil_space_type sp);
		return sp == CIL_SP_BYTE;
	endfunction

	function automatic logic [31:0] bit_at(input int pos, input logic val);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[pos] = val;
		return v;
	endfunction

	localparam logic [31:0] IMPL_BITS = (CIL_WRITABLE_BITS | CIL_NMI_BITS)
		& ~(CIL_HAS_ACCEL ? 32'h0000_0000 : CIL_ACCEL_BITS);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [31:0] latch_ff;
	logic [31:0] nxt_latch;
	logic [31:0] mask_ff;
	logic [4:0] mode_ff;
	logic [31:0] rdata_ff;
	logic irq_req_ff;
	logic [4:0] irq_idx_ff;
	cil_state_type state_ff;
	logic [31:0] timer_prev_ff;
	logic hw_reset_sync;
	logic hw_reset_prev_ff;
	logic [31:0] set_vec;
	logic [31:0] pend;
	logic pick_any;
	logic [4:0] pick_idx;
	logic timer_zero;
	logic seq_restricted;
	logic addr_bad;
	logic parity_hit;

	cil_sync2 u_rst_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.d(hardware_reset_pin),
		.q(hw_reset_sync)
	);

	// ----------------------------------------
	// Event conditions
	// ----------------------------------------
	assign timer_zero = (timer_prev_ff != 32'h0000_0000) && (timer_count_value == 32'h0000_0000);

	assign seq_restricted = evt.loop_tail_dly_branch
		| (evt.nest_e2_in_arith & (evt.nest_last_gap1 | evt.nest_l2_branch));

	assign addr_bad = (evt.acc_valid & evt.acc_narrow & !is_byte_space(evt.acc_space))
		| (evt.mod_valid & evt.mod_sw & !is_byte_space(evt.mod_space))
		| (evt.mod_valid & evt.mod_nw
		& (evt.mod_space == CIL_SP_LONG || evt.mod_space == CIL_SP_SHORT));

	// Checking enabled per access kind; only valid, non-aborted accesses count
	assign parity_hit = |(evt.par_err & evt.par_valid & ~evt.par_abort
		& {mode_ff[CIL_MODE_SYS_PAR], mode_ff[CIL_MODE_DATA_PAR],
		mode_ff[CIL_MODE_INSTR_PAR]});

	always_comb begin
		set_vec = 32'h0000_0000;
		set_vec |= bit_at(CIL_BIT_DEBUG_TOP, evt.debug_top | evt.debug_break);
		set_vec |= bit_at(CIL_BIT_RESET, (hw_reset_sync & !hw_reset_prev_ff)
			| evt.soft_reset);
		set_vec |= bit_at(CIL_BIT_DEBUG_LOW_PRIO, evt.debug_low);
		set_vec |= bit_at(CIL_BIT_FLOAT_INVALID, |evt.flt_inv);
		set_vec |= bit_at(CIL_BIT_FLOAT_UNDERFLOW, |evt.flt_unf);
		set_vec |= bit_at(CIL_BIT_FLOAT_OVERFLOW, |evt.flt_ovf);
		set_vec |= bit_at(CIL_BIT_FIXED_OVERFLOW, |evt.fix_ovf);
		set_vec |= bit_at(CIL_BIT_TIMER_LOW, timer_zero);
		set_vec |= bit_at(CIL_BIT_TIMER_HIGH, timer_zero);
		set_vec |= bit_at(CIL_BIT_RING_WRAP_IDX15, evt.ring_wrap15);
		set_vec |= bit_at(CIL_BIT_RING_WRAP_IDX7, evt.ring_wrap7);
		set_vec |= bit_at(CIL_BIT_RESTRICTED_SEQ, seq_restricted);
		set_vec |= bit_at(CIL_BIT_SYSTEM_EVENT, evt.sys_event
			& (!sys_event_in_service | mode_ff[CIL_MODE_SELF_NEST]));
		set_vec |= bit_at(CIL_BIT_RECURSIVE_FILTER, evt.iir_done & CIL_HAS_ACCEL);
		set_vec |= bit_at(CIL_BIT_FIR_FILTER, evt.fir_done & CIL_HAS_ACCEL);
		set_vec |= bit_at(CIL_BIT_BREAKPOINT, evt.breakpoint);
		set_vec |= bit_at(CIL_BIT_BAD_ADDRESS, addr_bad);
		set_vec |= bit_at(CIL_BIT_STACK_OVERFLOW, |evt.stack_full);
		set_vec |= bit_at(CIL_BIT_BAD_INPUT, evt.io_reg_flag | evt.unaligned_flag);
		set_vec |= bit_at(CIL_BIT_BAD_OPCODE, evt.bad_opcode);
		set_vec |= bit_at(CIL_BIT_PARITY, parity_hit);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			timer_prev_ff <= 32'h0000_0000;
			hw_reset_prev_ff <= 1'b0;
		end else begin
			timer_prev_ff <= timer_count_value;
			hw_reset_prev_ff <= hw_reset_sync;
		end
	end

	// ----------------------------------------
	// Latch update
	// ----------------------------------------
	// Order: software write, then vector clear, then hardware sets win last
	always_comb begin
		nxt_latch = latch_ff;
		if (bus.wr && bus.addr == CIL_OFS_LATCH) begin
			nxt_latch = (latch_ff & ~CIL_WRITABLE_BITS)
				| (bus.wdata & CIL_WRITABLE_BITS);
		end
		if (state_ff == CIL_ST_WAIT && vec_ack) begin
			nxt_latch = nxt_latch & ~bit_at(int'(irq_idx_ff), 1'b1);
		end
		nxt_latch = (nxt_latch | set_vec) & IMPL_BITS;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			latch_ff <= CIL_LATCH_RST;
		end else begin
			latch_ff <= nxt_latch;
		end
	end

	// ----------------------------------------
	// Mask and mode registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			mask_ff <= CIL_MASK_RST;
			mode_ff <= CIL_MODE_RST;
		end else begin
			if (bus.wr && bus.addr == CIL_OFS_MASK) begin
				mask_ff <= bus.wdata & CIL_WRITABLE_BITS;
			end
			if (bus.wr && bus.addr == CIL_OFS_MODE) begin
				mode_ff <= bus.wdata[4:0];
			end
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdata_ff <= 32'h0000_0000;
		end else if (bus.rd) begin
			unique case (bus.addr)
				CIL_OFS_LATCH: rdata_ff <= latch_ff;
				CIL_OFS_MASK: rdata_ff <= mask_ff | CIL_NMI_BITS;
				CIL_OFS_MODE: rdata_ff <= {27'h0000000, mode_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Priority request to the sequencer
	// ----------------------------------------
	// Non-maskable bits bypass both mask and global enable
	assign pend = latch_ff & ((mask_ff & {32{mode_ff[CIL_MODE_GLOBAL_EN]}})
		| CIL_NMI_BITS);

	cil_prio_pick u_pick (
		.pend(pend),
		.any(pick_any),
		.idx(pick_idx)
	);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_ff <= CIL_ST_IDLE;
			irq_req_ff <= 1'b0;
			irq_idx_ff <= 5'h00;
		end else begin
			unique case (state_ff)
				CIL_ST_IDLE: begin
					if (pick_any) begin
						state_ff <= CIL_ST_WAIT;
						irq_req_ff <= 1'b1;
						irq_idx_ff <= pick_idx;
					end
				end
				CIL_ST_WAIT: begin
					if (vec_ack) begin
						state_ff <= CIL_ST_IDLE;
						irq_req_ff <= 1'b0;
					end
				end
				default: begin
					state_ff <= CIL_ST_IDLE;
					irq_req_ff <= 1'b0;
				end
			endcase
		end
	end

	assign rdata = rdata_ff;
	assign irq_req = irq_req_ff;
	assign irq_idx = irq_idx_ff;
	assign interrupt_latch = latch_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	chk_soft_write_sets: assert property (
		bus.wr && bus.addr == CIL_OFS_LATCH && bus.wdata[CIL_BIT_SOFT_REQUEST_0]
		&& !(state_ff == CIL_ST_WAIT && vec_ack)
		|=> latch_ff[CIL_BIT_SOFT_REQUEST_0])
		else $error("software latch bit not set by write");

	// Nothing unmasked and no unmaskable bit: the sequencer must stay quiet
	chk_masked_no_req: assert property (
		state_ff == CIL_ST_IDLE && (latch_ff & CIL_NMI_BITS) == 32'h0000_0000
		&& (!mode_ff[CIL_MODE_GLOBAL_EN] || (latch_ff & mask_ff) == 32'h0000_0000)
		|=> !irq_req_ff)
		else $error("masked source picked");

	chk_timer_both: assert property (
		$past(timer_count_value) != 32'h0000_0000 && timer_count_value == 32'h0000_0000
		##1 1'b1 |-> latch_ff[CIL_BIT_TIMER_LOW] && latch_ff[CIL_BIT_TIMER_HIGH])
		else $error("timer expiry did not set both latches");

	chk_sys_evt_blocked: assert property (
		!latch_ff[CIL_BIT_SYSTEM_EVENT] && evt.sys_event && sys_event_in_service
		&& !mode_ff[CIL_MODE_SELF_NEST] && !(state_ff == CIL_ST_WAIT)
		&& !(bus.wr && bus.addr == CIL_OFS_LATCH)
		|=> !latch_ff[CIL_BIT_SYSTEM_EVENT])
		else $error("system event latched while in service without self-nest");

	chk_parity_abort: assert property (
		!latch_ff[CIL_BIT_PARITY] && (evt.par_err & ~evt.par_abort & evt.par_valid) == 3'h0
		&& !(bus.wr && bus.addr == CIL_OFS_LATCH)
		|=> !latch_ff[CIL_BIT_PARITY])
		else $error("parity latch set by aborted or invalid access");

	chk_nmi_readonly: assert property (
		bus.wr && bus.addr == CIL_OFS_LATCH && !(state_ff == CIL_ST_WAIT && vec_ack)
		|=> latch_ff[1:0] == ($past(latch_ff[1:0]) | $past(set_vec[1:0])))
		else $error("read-only latch bits changed by write");

	chk_debug_top_wins: assert property (
		state_ff == CIL_ST_IDLE && latch_ff[CIL_BIT_DEBUG_TOP]
		|=> irq_req_ff && irq_idx_ff == 5'h00)
		else $error("top debug interrupt not given priority");

	chk_hold_until_ack: assert property (
		state_ff == CIL_ST_WAIT && !vec_ack && latch_ff[irq_idx_ff]
		&& !(bus.wr && bus.addr == CIL_OFS_LATCH)
		|=> latch_ff[$past(irq_idx_ff)])
		else $error("latched bit dropped without ack or write");

	chk_read_latency: assert property (
		bus.rd && bus.addr == CIL_OFS_LATCH |=> rdata_ff == $past(latch_ff))
		else $error("read data not one cycle after strobe");

	chk_rdata_idle: assert property (
		!bus.rd |=> rdata_ff == 32'h0000_0000)
		else $error("read data present without a read strobe");

	// A hardware set in the same cycle as a write or an acknowledge is never lost
	chk_set_beats_clear: assert property (
		(set_vec & IMPL_BITS) != 32'h0000_0000
		|=> (latch_ff & $past(set_vec & IMPL_BITS)) == $past(set_vec & IMPL_BITS))
		else $error("hardware set lost to a same-cycle clear");

	chk_debug_low_rank: assert property (
		state_ff == CIL_ST_IDLE && latch_ff[CIL_BIT_DEBUG_LOW_PRIO]
		&& mask_ff[CIL_BIT_DEBUG_LOW_PRIO] && mode_ff[CIL_MODE_GLOBAL_EN]
		|=> irq_req_ff && irq_idx_ff <= 5'(CIL_BIT_DEBUG_LOW_PRIO))
		else $error("software interrupt ranked above low-priority debug");

	chk_ack_clears: assert property (
		state_ff == CIL_ST_WAIT && vec_ack && !set_vec[irq_idx_ff]
		&& !(bus.wr && bus.addr == CIL_OFS_LATCH)
		|=> !latch_ff[$past(irq_idx_ff)] && !irq_req_ff)
		else $error("acknowledged latch bit or request not cleared");

	chk_req_stands: assert property (
		state_ff == CIL_ST_WAIT && !vec_ack |=> irq_req_ff && $stable(irq_idx_ff))
		else $error("request dropped or changed before acknowledge");

	chk_pin_sets_reset: assert property (
		$rose(hw_reset_sync) |=> latch_ff[CIL_BIT_RESET])
		else $error("reset pin did not set the reset latch bit");

	cov_soft_req: cover property (
		bus.wr && bus.addr == CIL_OFS_LATCH ##[1:4] irq_req_ff && irq_idx_ff >= 5'd28);
	cov_timer_zero: cover property (timer_zero);
	cov_ack_clear: cover property (state_ff == CIL_ST_WAIT && vec_ack);
	cov_self_nest: cover property (evt.sys_event && sys_event_in_service
		&& mode_ff[CIL_MODE_SELF_NEST]);

endmodule // cil_latch_top

// ---- tb/cil_seq_model.sv ----
// Sequencer stand-in that acknowledges interrupt requests after a set delay
`timescale 1ns/100ps
module cil_seq_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic irq_req,
	input wire logic [3:0] dly,
	output logic vec_ack
);
	logic [3:0] cnt_ff;

	// One acknowledge per request; the ack cycle itself is skipped
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt_ff <= 4'h0;
			vec_ack <= 1'b0;
		end else begin
			vec_ack <= 1'b0;
			if (irq_req && !vec_ack) begin
				cnt_ff <= (cnt_ff == dly) ? 4'h0 : cnt_ff + 4'h1;
				vec_ack <= (cnt_ff == dly);
			end
		end
	end
endmodule // cil_seq_model

// ---- tb/cil_latch_top_bench.sv ----
// Self-checking bench for the core interrupt latch
`timescale 1ns/100ps
module cil_latch_top_bench;
	import cil_pkg::*;
	logic clk_sys, rstn, pin, svc, vec_ack, irq_req;
	cil_bus_type bus;
	cil_evt_type evt;
	logic [31:0] tcnt, rdata, latch, m;
	logic [4:0] irq_idx;
	logic [3:0] dly;
	logic [4:0] q[$];
	logic [4:0] eq[$];
	int fails, n_tests, seed;
	localparam int XB [30] = '{27, 26, 25, 24, 23, 23, 21, 5, 20, 20, 20, -1, 15, 14, 13,
		12, 8, -1, 8, -1, 8, 7, 6, 6, 4, 3, 3, -1, -1, 3};

	cil_latch_top cil_latch_top_i (.clk_sys(clk_sys), .rstn(rstn), .hardware_reset_pin(pin),
		.bus(bus), .rdata(rdata), .evt(evt), .timer_count_value(tcnt),
		.sys_event_in_service(svc), .vec_ack(vec_ack), .irq_req(irq_req), .irq_idx(irq_idx),
		.interrupt_latch(latch));
	cil_seq_model cil_seq_model_i (.clk_sys(clk_sys), .rstn(rstn), .irq_req(irq_req),
		.dly(dly), .vec_ack(vec_ack));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic done(input string s);
		$display("Test %s finished at %0t", s, $time);
	endtask

	task automatic bus_op(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk_sys);
		bus <= '0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus_op(a, 32'h0, 1'b0);
		chk(rdata, exp, "read");
	endtask

	task automatic wl(input logic [31:0] d);
		bus_op(CIL_OFS_LATCH, d, 1'b1);
		m = (m & ~CIL_WRITABLE_BITS) | (d & CIL_WRITABLE_BITS);
		chk(latch, m, "latch write");
	endtask

	task automatic pulse(input cil_evt_type e, input logic [31:0] x);
		@(posedge clk_sys);
		evt <= e;
		@(posedge clk_sys);
		evt <= '0;
		m = m | x;
		#1;
		chk(latch, m, "event");
	endtask

	task automatic acks();
		for (int i = 0; i < 80 && q.size() < eq.size(); i++)
			@(posedge clk_sys);
		#1;
		chk(32'(q.size()), 32'(eq.size()), "ack count");
		while (q.size() > 0 && eq.size() > 0)
			chk(32'(q.pop_front()), 32'(eq.pop_front()), "ack index");
		chk(latch, m, "latch after ack");
		eq.delete();
		q.delete();
	endtask

	function automatic void mk(input int k, output cil_evt_type e);
		e = '0;
		case (k)
			0: e.debug_low = 1'b1;
			1: e.flt_inv = 2'b10;
			2: e.flt_unf = 2'b01;
			3: e.flt_ovf = 2'b10;
			4: e.fix_ovf = 2'b01;
			5: e.fix_ovf = 2'b10;
			6: e.ring_wrap15 = 1'b1;
			7: e.ring_wrap7 = 1'b1;
			8: e.loop_tail_dly_branch = 1'b1;
			9: {e.nest_e2_in_arith, e.nest_last_gap1} = 2'b11;
			10: {e.nest_e2_in_arith, e.nest_l2_branch} = 2'b11;
			11: {e.nest_last_gap1, e.nest_l2_branch} = 2'b11;
			12: e.sys_event = 1'b1;
			13: e.iir_done = 1'b1;
			14: e.fir_done = 1'b1;
			15: e.breakpoint = 1'b1;
			16: {e.acc_valid, e.acc_narrow} = 2'b11;
			17: begin
				{e.acc_valid, e.acc_narrow} = 2'b11;
				e.acc_space = CIL_SP_BYTE;
			end
			18: {e.mod_valid, e.mod_sw} = 2'b11;
			19: {e.mod_valid, e.mod_nw} = 2'b11;
			20: begin
				{e.mod_valid, e.mod_nw} = 2'b11;
				e.mod_space = CIL_SP_SHORT;
			end
			21: e.stack_full = 3'b100;
			22: e.io_reg_flag = 1'b1;
			23: e.unaligned_flag = 1'b1;
			24: e.bad_opcode = 1'b1;
			25: {e.par_err[0], e.par_valid[0]} = 2'b11;
			26: {e.par_err[2], e.par_valid[2]} = 2'b11;
			27: {e.par_err[1], e.par_valid[1], e.par_abort[1]} = 3'h7;
			28: e.par_err[1] = 1'b1;
			default: {e.par_err[1], e.par_valid[1]} = 2'b11;
		endcase
	endfunction

	always @(posedge clk_sys)
		if (rstn && vec_ack && irq_req)
			q.push_back(irq_idx);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial begin
		#(4 * 20000);
		fails++;
		finish_test();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		cil_evt_type e;
		rstn = 1'b0;
		bus = '0;
		evt = '0;
		tcnt = 32'h0;
		pin = 1'b0;
		svc = 1'b0;
		dly = 4'h1;
		m = 32'h0;
		seed = $urandom(42);
		repeat (20) @(posedge clk_sys);
		#1;
		chk(latch, 32'h0000_0002, "reset value");
		@(posedge clk_sys);
		rstn <= 1'b1;
		eq.push_back(5'd1);
		acks();
		rd(CIL_OFS_MASK, 32'h0000_0003);
		done("reset");
		bus_op(CIL_OFS_MODE, 32'hffff_ffee, 1'b1);
		rd(CIL_OFS_MODE, 32'h0000_000e);
		bus_op(8'h0c, 32'hffff_ffff, 1'b1);
		rd(8'h0c, 32'h0);
		wl($urandom());
		rd(CIL_OFS_LATCH, m);
		wl(32'hffff_ffff);
		wl(32'h0);
		done("registers");
		for (int k = 0; k < 30; k++) begin
			mk(k, e);
			pulse(e, (XB[k] < 0) ? 32'h0 : 32'h1 << XB[k]);
			wl(32'h0);
		end
		@(posedge clk_sys);
		svc <= 1'b1;
		mk(12, e);
		pulse(e, 32'h0);
		bus_op(CIL_OFS_MODE, 32'h0000_000f, 1'b1);
		pulse(e, 32'h0000_8000);
		wl(32'h0);
		done("events");
		bus_op(CIL_OFS_MASK, 32'h1800_0810, 1'b1);
		rd(CIL_OFS_MASK, 32'h1800_0813);
		bus_op(CIL_OFS_MODE, 32'h0000_001e, 1'b1);
		for (int i = 2; i >= 0; i--) begin
			@(posedge clk_sys);
			tcnt <= 32'(i);
		end
		m = m | 32'h0040_0000;
		eq.push_back(5'd11);
		acks();
		wl(32'h0);
		@(posedge clk_sys);
		dly <= 4'h6;
		wl(32'h3800_0010);
		eq = '{5'd4, 5'd27, 5'd28};
		m = 32'h2000_0000;
		acks();
		wl(32'h0);
		done("requests");
		e = '0;
		{e.debug_top, e.soft_reset} = 2'b11;
		pulse(e, 32'h0000_0003);
		eq = '{5'd0, 5'd1};
		m = 32'h0;
		acks();
		e = '0;
		e.debug_break = 1'b1;
		pulse(e, 32'h0000_0001);
		eq.push_back(5'd0);
		m = 32'h0;
		acks();
		@(posedge clk_sys);
		pin <= 1'b1;
		eq.push_back(5'd1);
		acks();
		@(posedge clk_sys);
		pin <= 1'b0;
		done("unmaskable");
		finish_test();
	end
endmodule // cil_latch_top_bench
